// file: src/ddg_guard.sv
// ddr2 command timing guard: issues commands once their spacings elapse, but refresh, mode set and self refresh entry skip the precharge wait
`timescale 1ns/1ps
module ddg_guard
	import ddg_pkg::*;
#(
	parameter int GRADE   = GRADE_400_333,
	parameter bit PAGE_1K = 1'b0,
	parameter int BL      = 4
) (
	// clock and reset
	input  wire logic        I_MCLK,
	input  wire logic        I_RSTN,
	// user request port
	input  wire logic        I_REQ_VALID,
	input  wire ddg_req_t    I_REQ,
	input  wire logic [2:0]  I_AL,
	input  wire logic [2:0]  I_WL,
	output logic             O_REQ_READY,
	output logic             O_REF_DUE,
	output logic [3:0]       O_RD_EDGES,
	// memory pins
	output logic             O_CK,
	output ddg_pins_t        O_DDR,
	input  wire logic        I_DQS_I,
	output logic             O_DQS_O,
	output logic             O_DQS_OE
);

	// cycle counts, loaded as count minus one
	localparam int RCD_PS = (GRADE == GRADE_400_444) ? T_RCD_SLOW_PS : T_RCD_FAST_PS;
	localparam int WTR_PS = (GRADE == GRADE_533_444) ? T_WTR_533_PS : T_WTR_400_PS;
	localparam int RRD_PS = PAGE_1K ? T_RRD_1K_PS : T_RRD_2K_PS;
	localparam logic [CNT_W-1:0] L_RFC  = CNT_W'(ddg_cyc(T_RFC_PS) - 1);
	localparam logic [CNT_W-1:0] L_RCD  = CNT_W'(ddg_cyc(RCD_PS) - 1);
	localparam logic [CNT_W-1:0] L_RP   = CNT_W'(ddg_cyc(RCD_PS) - 1);
	localparam logic [CNT_W-1:0] L_RRD  = CNT_W'(ddg_cyc(RRD_PS) - 1);
	localparam logic [CNT_W-1:0] L_WTR  = CNT_W'(ddg_cyc(WTR_PS) - 1);
	localparam logic [CNT_W-1:0] L_DAL  = CNT_W'(ddg_cyc(T_WR_PS) + ddg_cyc(RCD_PS) - 1);
	localparam logic [CNT_W-1:0] L_RDAP = CNT_W'(ddg_cyc(RCD_PS) + BL - 1);
	localparam logic [CNT_W-1:0] L_MRD  = CNT_W'(T_MRD_CK * CK_DIV - 1);
	localparam logic [CNT_W-1:0] L_XSC  = CNT_W'(T_XSC_CK * CK_DIV - 1);
	localparam logic [CNT_W-1:0] L_XPNR = CNT_W'(T_XPNR_CK * CK_DIV - 1);
	localparam logic [CNT_W-1:0] L_XARD = CNT_W'(T_XARD_CK * CK_DIV - 1);
	localparam logic [CNT_W-1:0] L_REFI = CNT_W'(T_REFI_PS / CLK_PS - 1);
	localparam logic [CNT_W-1:0] BL_C   = CNT_W'(BL);

	// counter step toward zero
	function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] x);
		return (x == '0) ? x : x - 1'b1;
	endfunction : dec

	logic                   ck;
	logic                   slot;
	ddg_pmode_t             pmode;
	logic [NBANK-1:0]       open;
	logic [CNT_W-1:0]       dev_wait;
	logic [CNT_W-1:0]       nr_wait;
	logic [CNT_W-1:0]       rd_wait;
	logic [CNT_W-1:0]       act_wait;
	logic [CNT_W-1:0]       col_wait [NBANK];
	logic [CNT_W-1:0]       bank_wait [NBANK];
	logic                   wact;
	logic                   wap;
	logic [BA_W-1:0]        wbank;
	logic [CNT_W-1:0]       wpos;
	logic [CNT_W-1:0]       wl2;
	logic                   burst_end;
	logic [CNT_W-1:0]       p;
	logic [CNT_W-1:0]       l_xprd;
	logic [CNT_W-1:0]       ref_tmr;
	logic [OWED_W-1:0]      owed;
	logic                   ref_go;
	logic                   req_ok;
	logic                   next_issue;
	logic                   next_grant;
	ddg_op_t                next_op;
	logic                   next_cke;
	logic [BA_W-1:0]        iss_ba;
	logic [ADDR_W-1:0]      iss_addr;
	logic                   dqs_s1;
	logic                   dqs_s2;
	logic                   dqs_s3;
	logic [CNT_W-1:0]       rwin;
	logic [3:0]             rd_edges;

	// memory clock by division, commands launched as it falls
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) ck <= 1'b0;
		else         ck <= ~ck;
	end
	assign slot = ck;

	// refresh owed when all banks are closed and the device is awake
	assign ref_go = (owed != '0) && (open == '0) && (pmode == PM_ON) && (dev_wait == '0) && !wact;

	// legality of the user's request against the counters that govern its command
	always_comb begin
		req_ok = 1'b0;
		case (I_REQ.op)
			OP_NOP: req_ok = 1'b1;
			OP_MRS, OP_REF, OP_SRE: req_ok = (pmode == PM_ON) && (open == '0) && (dev_wait == '0) &&
			                                 (nr_wait == '0) && !wact;
			OP_PDE: req_ok = (pmode == PM_ON) && (dev_wait == '0) && (nr_wait == '0) && !wact;
			OP_PDX: req_ok = (pmode == PM_APD) || (pmode == PM_PPD);
			OP_SRX: req_ok = (pmode == PM_SR);
			OP_ACT: req_ok = (pmode == PM_ON) && (dev_wait == '0) && (nr_wait == '0) && (act_wait == '0) &&
			                 !open[I_REQ.ba] && (bank_wait[I_REQ.ba] == '0);
			OP_RD, OP_RDA: req_ok = (pmode == PM_ON) && (dev_wait == '0) && (rd_wait == '0) && !wact &&
			                        open[I_REQ.ba] && (col_wait[I_REQ.ba] == '0);
			OP_WR, OP_WRA: req_ok = (pmode == PM_ON) && (dev_wait == '0) && (nr_wait == '0) && !wact &&
			                        open[I_REQ.ba] && (col_wait[I_REQ.ba] == '0);
			OP_PRE: req_ok = (pmode == PM_ON) && (dev_wait == '0) && (nr_wait == '0) && !wact;
			default: req_ok = 1'b0;
		endcase
	end

	// slot arbitration: refresh first, then the user, else nop
	always_comb begin
		next_issue = 1'b0;
		next_grant = 1'b0;
		next_op    = OP_NOP;
		iss_ba     = I_REQ.ba;
		iss_addr   = I_REQ.addr;
		if (slot && ref_go) begin
			next_issue = 1'b1;
			next_op    = OP_REF;
		end else if (slot && I_REQ_VALID && req_ok) begin
			next_issue = 1'b1;
			next_grant = 1'b1;
			next_op    = I_REQ.op;
		end
		if (next_op == OP_RDA || next_op == OP_WRA) iss_addr[AP_BIT] = 1'b1;
		if (next_op == OP_RD || next_op == OP_WR)   iss_addr[AP_BIT] = 1'b0;
	end

	// clock enable follows power state commands
	always_comb begin
		next_cke = O_DDR.cke;
		case (next_op)
			OP_SRE, OP_PDE: next_cke = 1'b0;
			OP_SRX, OP_PDX: next_cke = 1'b1;
			default:        next_cke = O_DDR.cke;
		endcase
	end

	// command pins, held for a whole memory clock, gaps filled with nop
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_DDR <= '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, ba: '0, addr: '0};
		end else if (slot) begin
			O_DDR.cke <= next_cke;
			{O_DDR.cs_n, O_DDR.ras_n, O_DDR.cas_n, O_DDR.we_n} <= ddg_encode(next_op);
			O_DDR.ba   <= iss_ba;
			O_DDR.addr <= iss_addr;
		end else if (!O_DDR.cke && I_RSTN && pmode == PM_ON && !next_issue) begin
			O_DDR.cke <= 1'b1;                // first clock out of reset
		end
	end

	// power state tracking
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) pmode <= PM_ON;
		else if (next_issue) begin
			case (next_op)
				OP_SRE:         pmode <= PM_SR;
				OP_PDE:         pmode <= (open != '0) ? PM_APD : PM_PPD;
				OP_SRX, OP_PDX: pmode <= PM_ON;
				default:        pmode <= pmode;
			endcase
		end
	end

	// device-wide waits
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			dev_wait <= '0;
			nr_wait  <= '0;
			act_wait <= '0;
		end else begin
			dev_wait <= dec(dev_wait);
			nr_wait  <= dec(nr_wait);
			act_wait <= dec(act_wait);
			if (next_issue && next_op == OP_REF) dev_wait <= L_RFC;
			if (next_issue && next_op == OP_MRS) dev_wait <= L_MRD;
			if (next_issue && next_op == OP_SRX) dev_wait <= L_XSC;
			if (next_issue && next_op == OP_PDX) nr_wait  <= L_XPNR;
			if (next_issue && next_op == OP_ACT) act_wait <= L_RRD;
		end
	end

	// read wait after power down exit depends on which power down
	always_comb begin
		if (I_AL >= 3'(T_XPRD_CK)) l_xprd = '0;
		else l_xprd = CNT_W'((T_XPRD_CK - int'(I_AL)) * CK_DIV - 1);
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) rd_wait <= '0;
		else if (burst_end) rd_wait <= L_WTR;
		else if (next_issue && next_op == OP_PDX && pmode == PM_APD) rd_wait <= L_XARD;
		else if (next_issue && next_op == OP_PDX) rd_wait <= l_xprd;
		else rd_wait <= dec(rd_wait);
	end

	// per-bank state and counters
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic hit;
		logic pre_hit;
		assign hit     = next_issue && (iss_ba == BA_W'(b));
		assign pre_hit = next_issue && next_op == OP_PRE && (iss_addr[AP_BIT] || iss_ba == BA_W'(b));

		always_ff @(posedge I_MCLK) begin
			if (!I_RSTN) open[b] <= 1'b0;
			else if (hit && next_op == OP_ACT) open[b] <= 1'b1;
			else if (pre_hit || (hit && (next_op == OP_RDA || next_op == OP_WRA))) open[b] <= 1'b0;
		end

		always_ff @(posedge I_MCLK) begin
			if (!I_RSTN) col_wait[b] <= '0;
			else if (hit && next_op == OP_ACT) col_wait[b] <= L_RCD;
			else col_wait[b] <= dec(col_wait[b]);
		end

		always_ff @(posedge I_MCLK) begin
			if (!I_RSTN) bank_wait[b] <= '0;
			else if (burst_end && wap && wbank == BA_W'(b)) bank_wait[b] <= L_DAL;
			else if (hit && next_op == OP_RDA) bank_wait[b] <= L_RDAP;
			else if (pre_hit) bank_wait[b] <= L_RP;
			else bank_wait[b] <= dec(bank_wait[b]);
		end
	end

	// write strobe framing, position counted from the command launch
	assign p         = wpos + 1'b1;
	assign burst_end = wact && (p == wl2 + BL_C);

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			wact  <= 1'b0;
			wap   <= 1'b0;
			wbank <= '0;
			wpos  <= '0;
			wl2   <= '0;
		end else if (next_issue && (next_op == OP_WR || next_op == OP_WRA)) begin
			wact  <= 1'b1;
			wap   <= (next_op == OP_WRA);
			wbank <= iss_ba;
			wpos  <= '0;
			wl2   <= CNT_W'({I_WL, 1'b0});
		end else if (burst_end) begin
			wact <= 1'b0;
		end else if (wact) begin
			wpos <= p;
		end
	end

	// preamble one half clock, burst edges, postamble one half clock
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_DQS_OE <= 1'b0;
			O_DQS_O  <= 1'b0;
		end else begin
			O_DQS_OE <= wact && (p >= wl2) && (p <= wl2 + BL_C);
			O_DQS_O  <= wact && (p > wl2) && (p <= wl2 + BL_C) && p[0] != wl2[0];
		end
	end

	// refresh interval timer and owed count, a tick and a refresh issue in the same cycle cancel
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			ref_tmr <= L_REFI;
			owed    <= '0;
		end else begin
			ref_tmr <= (ref_tmr == '0 || pmode == PM_SR) ? L_REFI : ref_tmr - 1'b1;
			if (ref_tmr == '0 && pmode != PM_SR) begin
				if (!(next_issue && next_op == OP_REF) && owed != OWED_W'(OWED_MAX)) owed <= owed + 1'b1;
			end else if (next_issue && next_op == OP_REF && owed != '0) begin
				owed <= owed - 1'b1;
			end
		end
	end

	// read strobe synchroniser and edge counter inside the read window
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			dqs_s1 <= 1'b0;
			dqs_s2 <= 1'b0;
			dqs_s3 <= 1'b0;
		end else begin
			dqs_s1 <= I_DQS_I;
			dqs_s2 <= dqs_s1;
			dqs_s3 <= dqs_s2;
		end
	end

	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			rwin     <= '0;
			rd_edges <= '0;
		end else if (next_issue && (next_op == OP_RD || next_op == OP_RDA)) begin
			rwin     <= CNT_W'({I_WL, 1'b0}) + CNT_W'(CK_DIV) + BL_C + CNT_W'(RD_MARGIN);
			rd_edges <= '0;
		end else begin
			rwin <= dec(rwin);
			if (rwin != '0 && dqs_s2 && !dqs_s3) rd_edges <= rd_edges + 1'b1;
		end
	end

	// registered status outputs
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			O_REQ_READY <= 1'b0;
			O_REF_DUE   <= 1'b0;
			O_RD_EDGES  <= '0;
			O_CK        <= 1'b0;
		end else begin
			O_REQ_READY <= next_grant;
			O_REF_DUE   <= (owed != '0);
			O_RD_EDGES  <= rd_edges;
			O_CK        <= ~ck;
		end
	end

endmodule : ddg_guard

// file: pkg/ddg_pkg.sv
// constants, types and helpers for the ddr2 command timing guard
package ddg_pkg;

	// clock and timing figures
	localparam int CLK_PS        = 20000;   // system clock period in ps
	localparam int CK_DIV        = 2;       // system clocks per memory clock
	localparam int T_RFC_PS      = 105000;
	localparam int T_WR_PS       = 15000;
	localparam int T_REFI_PS     = 7800000;
	localparam int T_RCD_FAST_PS = 15000;   // 400 3/3/3 and 533 4/4/4
	localparam int T_RCD_SLOW_PS = 20000;   // 400 4/4/4
	localparam int T_RRD_2K_PS   = 10000;
	localparam int T_RRD_1K_PS   = 7500;
	localparam int T_WTR_400_PS  = 10000;
	localparam int T_WTR_533_PS  = 7500;
	localparam int T_MRD_CK      = 2;
	localparam int T_XSC_CK      = 200;
	localparam int T_XPNR_CK     = 2;
	localparam int T_XARD_CK     = 2;
	localparam int T_XPRD_CK     = 6;

	// speed grades
	localparam int GRADE_400_333 = 0;
	localparam int GRADE_400_444 = 1;
	localparam int GRADE_533_444 = 2;

	// widths and field positions
	localparam int CNT_W     = 10;
	localparam int NBANK     = 4;
	localparam int BA_W      = 2;
	localparam int ADDR_W    = 14;
	localparam int AP_BIT    = 10;
	localparam int OWED_W    = 4;
	localparam int OWED_MAX  = 8;
	localparam int RD_MARGIN = 4;           // extra sync delay on read strobe window

	typedef enum logic [3:0] {
		OP_NOP, OP_MRS, OP_REF, OP_SRE, OP_SRX, OP_PDE, OP_PDX,
		OP_ACT, OP_RD, OP_RDA, OP_WR, OP_WRA, OP_PRE
	} ddg_op_t;

	typedef enum logic [1:0] {PM_ON, PM_APD, PM_PPD, PM_SR} ddg_pmode_t;

	typedef struct packed {
		ddg_op_t             op;
		logic [BA_W-1:0]     ba;
		logic [ADDR_W-1:0]   addr;
	} ddg_req_t;

	typedef struct packed {
		logic                cke;
		logic                cs_n;
		logic                ras_n;
		logic                cas_n;
		logic                we_n;
		logic [BA_W-1:0]     ba;
		logic [ADDR_W-1:0]   addr;
	} ddg_pins_t;

	// pin codes cs_n,ras_n,cas_n,we_n
	localparam logic [3:0] PC_MRS = 4'h0;
	localparam logic [3:0] PC_REF = 4'h1;
	localparam logic [3:0] PC_PRE = 4'h2;
	localparam logic [3:0] PC_ACT = 4'h3;
	localparam logic [3:0] PC_WR  = 4'h4;
	localparam logic [3:0] PC_RD  = 4'h5;
	localparam logic [3:0] PC_NOP = 4'h7;

	// ps figure to system clocks, rounded up, never below one
	function automatic int ddg_cyc(input int ps);
		int c;
		c = (ps + CLK_PS - 1) / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction : ddg_cyc

	// command code to control pins
	function automatic logic [3:0] ddg_encode(input ddg_op_t op);
		case (op)
			OP_MRS:         return PC_MRS;
			OP_REF, OP_SRE: return PC_REF;
			OP_PRE:         return PC_PRE;
			OP_ACT:         return PC_ACT;
			OP_WR, OP_WRA:  return PC_WR;
			OP_RD, OP_RDA:  return PC_RD;
			default:        return PC_NOP;
		endcase
	endfunction : ddg_encode

endpackage : ddg_pkg

// file: verification/ddg_guard_assertions.sv
// concurrent checks on the command timing guard ports
`timescale 1ns/1ps
module ddg_guard_assertions
	import ddg_pkg::*;
#(
	parameter int GRADE   = GRADE_400_333,
	parameter bit PAGE_1K = 1'b0,
	parameter int BL      = 4
) (
	// clock and reset
	input  wire logic       I_MCLK,
	input  wire logic       I_RSTN,
	// request side
	input  wire logic [2:0] I_WL,
	// memory side
	input  wire logic       O_CK,
	input  wire ddg_pins_t  O_DDR,
	input  wire logic       O_DQS_O,
	input  wire logic       O_DQS_OE
);
	logic       ck_q, cke_q, boot, in_sr, cmd, slot, cke_rise;
	logic [3:0] code;
	logic [8:0] xs;
	logic [5:0] wp;
	logic [2:0] wl;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RSTN);

	// decode of the command on the pins
	assign code     = {O_DDR.cs_n, O_DDR.ras_n, O_DDR.cas_n, O_DDR.we_n};
	assign cmd      = !O_DDR.cs_n && code != PC_NOP;
	assign slot     = ck_q && !O_CK && cmd;
	assign cke_rise = O_DDR.cke && !cke_q;

	// edge history and self refresh exit count
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			ck_q  <= 1'b0;
			cke_q <= 1'b0;
			boot  <= 1'b1;
			in_sr <= 1'b0;
			xs    <= 9'h000;
		end else begin
			ck_q  <= O_CK;
			cke_q <= O_DDR.cke;
			if (cke_rise) boot <= 1'b0;
			if (slot && code == PC_REF && !O_DDR.cke) in_sr <= 1'b1;
			else if (cke_rise) in_sr <= 1'b0;
			if (cke_rise && in_sr) xs <= 9'h001;
			else if (xs != 9'h000 && xs < 9'h18f) xs <= xs + 9'h001;
			else xs <= 9'h000;
		end
	end

	// position inside a write burst, counted from the command
	always_ff @(posedge I_MCLK) begin
		if (!I_RSTN) begin
			wp <= 6'h00;
			wl <= 3'h0;
		end else if (slot && code == PC_WR) begin
			wp <= 6'h01;
			wl <= I_WL;
		end else if (wp != 6'h00 && wp < 2 * wl + BL + 1) wp <= wp + 6'h01;
		else wp <= 6'h00;
	end

	a_ref_gap: assert property (slot && code == PC_REF && O_DDR.cke |-> ##2 (!cmd) [*4])
		else $error("command too soon after refresh");
	a_mrs_gap: assert property (slot && code == PC_MRS |-> ##2 (!cmd) [*2])
		else $error("command too soon after mode set");
	a_sr_wait: assert property (xs != 9'h000 |-> !cmd)
		else $error("command too soon after self refresh exit");
	a_pd_exit: assert property (cke_rise && !boot |-> (!cmd) [*4])
		else $error("command too soon after clock enable rise");
	a_wr_early: assert property (wp != 6'h00 && wp == 2 * wl - 1 |-> !O_DQS_OE)
		else $error("write strobe driven too early");
	a_wr_first: assert property (wp != 6'h00 && wp == 2 * wl |-> O_DQS_OE && !O_DQS_O ##1 O_DQS_OE && O_DQS_O)
		else $error("first write strobe rise misplaced");
	a_wr_post: assert property (wp != 6'h00 && wp == 2 * wl + BL |-> O_DQS_OE && !O_DQS_O ##1 !O_DQS_OE)
		else $error("write strobe postamble wrong");
	a_wtr_block: assert property (wp != 6'h00 && wp <= 2 * wl + BL |-> !(slot && code == PC_RD))
		else $error("read during write turnaround");
endmodule : ddg_guard_assertions

bind ddg_guard ddg_guard_assertions #(.GRADE(GRADE), .PAGE_1K(PAGE_1K), .BL(BL)) u_assert (
	.I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_WL(I_WL), .O_CK(O_CK),
	.O_DDR(O_DDR), .O_DQS_O(O_DQS_O), .O_DQS_OE(O_DQS_OE));

// file: verification/ddg_dev_model.sv
// memory device model that answers reads with a framed strobe
`timescale 1ns/1ps
module ddg_dev_model
	import ddg_pkg::*;
#(
	parameter int BL = 4
) (
	// memory pins
	input  wire logic       i_ck,
	input  wire ddg_pins_t  i_ddr,
	input  wire logic [2:0] i_wl,
	output logic            o_dqs
);
	// parked high: inverse of the last driven low
	initial o_dqs = 1'b1;

	// read strobe, read latency one clock past write latency
	task automatic burst();
		int i;
		repeat (i_wl) @(posedge i_ck);
		o_dqs = 1'b0;
		for (i = 0; i < BL / 2; i++) begin
			@(posedge i_ck);
			o_dqs = 1'b1;
			@(negedge i_ck);
			o_dqs = 1'b0;
		end
		@(posedge i_ck);
		o_dqs = 1'b1;
	endtask : burst

	// commands are latched on the rising memory clock
	always @(posedge i_ck) begin
		if (i_ddr.cke && {i_ddr.cs_n, i_ddr.ras_n, i_ddr.cas_n, i_ddr.we_n} == PC_RD) begin
			fork
				burst();
			join_none
		end
	end
endmodule : ddg_dev_model

// file: verification/testbench.sv
// self-checking bench for the command timing guard
`timescale 1ns/1ps
module testbench import ddg_pkg::*;;
	localparam int WL = 3;
	localparam int BL = 4;
	localparam int AL = 2;
	logic [2:0] al = 3'h0;
	logic       clk = 1'b0, rst_n = 1'b0, valid = 1'b0, rdy, due, ck, dqs_o, dqs_oe, dev_dqs, dqs_pin;
	logic [3:0] edges;
	ddg_req_t   req = '0;
	ddg_pins_t  ddr;
	int         n_mismatch = 0, check_count = 0, cyc = 0;

	// clock, cycle count and strobe wire
	always #10 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	assign dqs_pin = dqs_oe ? dqs_o : dev_dqs;

	ddg_guard #(.BL(BL)) dut (.I_MCLK(clk), .I_RSTN(rst_n), .I_REQ_VALID(valid), .I_REQ(req),
		.I_AL(al), .I_WL(3'(WL)), .O_REQ_READY(rdy), .O_REF_DUE(due), .O_RD_EDGES(edges),
		.O_CK(ck), .O_DDR(ddr), .I_DQS_I(dqs_pin), .O_DQS_O(dqs_o), .O_DQS_OE(dqs_oe));
	ddg_dev_model #(.BL(BL)) u_dev (.i_ck(ck), .i_ddr(ddr), .i_wl(3'(WL)), .o_dqs(dev_dqs));

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict

	task automatic check_v(input logic [15:0] got, input logic [15:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask : check_v

	// present one request and hold it until accepted
	task automatic issue(input ddg_op_t op, input logic [1:0] ba, input logic [13:0] a, output int t);
		int k;
		@(posedge clk);
		#1;
		valid = 1'b1;
		req = '{op, ba, a};
		for (k = 0; k < 600 && rdy !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		valid = 1'b0;
		t = cyc;
		check_v(k < 600, 1, "request not accepted");
	endtask : issue

	// mode set, refresh, activates, write with precharge, reads
	task automatic t_spacing();
		int t0, t1, t2;
		issue(OP_MRS, 2'h0, 14'h0000, t0);
		issue(OP_REF, 2'h0, 14'h0000, t1);
		check_v(t1 - t0 >= 4, 1, "mode set spacing");
		issue(OP_ACT, 2'h0, 14'h0000, t2);
		check_v(t2 - t1 >= 6, 1, "refresh spacing");
		issue(OP_ACT, 2'h1, 14'h0000, t0);
		issue(OP_WRA, 2'h1, 14'h0400, t1);
		check_v(t1 - t0 >= 1, 1, "activate to write");
		issue(OP_RD, 2'h0, 14'h0000, t2);
		check_v(t2 - t1 >= 2 * WL + BL + 1, 1, "write to read turnaround");
		issue(OP_ACT, 2'h1, 14'h0000, t0);
		check_v(t0 - t1 >= 2 * WL + BL + 2, 1, "write recovery");
		issue(OP_RDA, 2'h1, 14'h0400, t2);
		check_v(t2 - t0 >= 1, 1, "activate to read");
		repeat (2 * WL + 2 + BL + 8) @(posedge clk);
		#1;
		check_v(edges >= BL / 2, 1, "read strobe edges");
		issue(OP_PRE, 2'h0, 14'h0400, t0);
	endtask : t_spacing

	// precharge and active power down exits
	task automatic t_power_down();
		int t0, t1, t2;
		al = 3'(AL);
		issue(OP_PDE, 2'h0, 14'h0000, t0);
		issue(OP_PDX, 2'h0, 14'h0000, t0);
		issue(OP_ACT, 2'h3, 14'h0000, t1);
		check_v(t1 - t0 >= 4, 1, "power down exit");
		issue(OP_RD, 2'h3, 14'h0000, t2);
		check_v(t2 - t0 >= 2 * (6 - AL), 1, "precharge power down read");
		issue(OP_PDE, 2'h0, 14'h0000, t0);
		issue(OP_PDX, 2'h0, 14'h0000, t0);
		issue(OP_RD, 2'h3, 14'h0000, t1);
		check_v(t1 - t0 >= 4, 1, "active power down read");
		issue(OP_PRE, 2'h0, 14'h0400, t0);
	endtask : t_power_down

	task automatic t_self_refresh();
		int t0, t1;
		issue(OP_SRE, 2'h0, 14'h0000, t0);
		repeat (20) @(posedge clk);
		issue(OP_SRX, 2'h0, 14'h0000, t0);
		issue(OP_ACT, 2'h2, 14'h0000, t1);
		check_v(t1 - t0 >= 400, 1, "self refresh exit");
		issue(OP_PRE, 2'h0, 14'h0400, t0);
	endtask : t_self_refresh

	// refresh owed while a bank is open, sent once banks close
	task automatic t_refresh();
		int k, t0;
		issue(OP_ACT, 2'h0, 14'h0000, t0);
		repeat (400) @(posedge clk);
		#1;
		check_v(due, 1, "refresh not owed");
		issue(OP_PRE, 2'h0, 14'h0400, t0);
		for (k = 0; k < 40 && !(ddr.cke && {ddr.cs_n, ddr.ras_n, ddr.cas_n, ddr.we_n} === PC_REF); k++) begin
			@(posedge clk);
			#1;
		end
		check_v(k < 40, 1, "refresh not issued");
	endtask : t_refresh

	// watchdog
	initial begin
		#100000;
		n_mismatch++;
		print_verdict();
	end

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_spacing();
		t_power_down();
		t_self_refresh();
		t_refresh();
		print_verdict();
	end
endmodule : testbench
